// ---- hdl/repeater_lane_config_regs.sv ----
`timescale 1ns/1ps
`default_nettype none

// Function
// - Writing one to reset bit restores every register to its default.
// - Power-down bits 7..4 are side A lanes 3..0, 3..0 side B.
// - Mask zero enables all lanes; all ones powers every lane down.
// - Power-down block bit set ignores the power-down pin; clear, pin ORed with register bits.
// - Idle block bit set takes lane idle away from the idle pin.
// - Rate block bit set takes lane rate away from the rate pin.
// - Idle auto bit selects automatic idle detect, else manual idle bit.
// - Manual idle clear keeps output on, detect off; set mutes output.
// - Rate auto bit selects detection, else rate bit forces 2.5 or 5.0.
// - Equalizer field: enable bit 5, gain stage 4:3, boost 2:0.
// - Equalizer gives 24 settings: three gain stages by eight boosts.
// - Write: address+write, ack, register byte, ack, data byte, ack.
// - Read: register byte as write, restart with read, one byte, NACK, stop.
module repeater_lane_config_regs
(
  // Clock, reset, enable
  input  wire logic                        clk,
  input  wire logic                        rst_n,
  input  wire logic                        ce,
  // Management bus pins
  input  wire logic                        mgmt_bus_enable_pin,
  input  wire logic [3:0]                  addrPins,
  input  wire logic                        scl,
  input  wire logic                        sdaIn,
  output logic                             sdaOut,
  output logic                             sdaOe,
  // External control pins and lane detectors
  input  wire logic                        power_down_pin,
  input  wire logic                        idlePin,
  input  wire logic                        ratePin,
  input  wire logic                        laneB0IdleDetected,
  input  wire logic                        laneB0HighRateDetected,
  // Lane controls
  output repeater_cfg_pkg::lane_ctrl_t     laneCtrl
);

  typedef enum logic [3:0] {
    S_IDLE, S_ADDR, S_ACK_ADDR, S_REG, S_ACK_REG,
    S_WDATA, S_ACK_DATA, S_READ, S_READ_ACK, S_IGNORE
  } bus_state_t;

  bus_state_t state;
  bus_state_t next_state;
  logic [3:0] bitCnt;
  logic [3:0] next_bitCnt;
  logic [7:0] shiftReg;
  logic [7:0] next_shiftReg;
  logic [7:0] regAddr;
  logic [7:0] next_regAddr;
  logic       readMode;
  logic       next_readMode;
  logic       hostAck;
  logic       next_hostAck;
  logic       sclPrev;
  logic       sdaPrev;
  logic       wrEn;
  logic [7:0] rdData;
  logic       sclRise;
  logic       sclFall;
  logic       startSeen;
  logic       stopSeen;
  logic [6:0] ownAddr;

  repeater_cfg_pkg::cfg_t      cfg;
  repeater_cfg_pkg::lane_ctrl_t next_laneCtrl;

  // Bus conditions from the previous pin sample
  assign sclRise   = scl && !sclPrev;
  assign sclFall   = !scl && sclPrev;
  assign startSeen = scl && sclPrev && sdaPrev && !sdaIn;
  assign stopSeen  = scl && sclPrev && !sdaPrev && sdaIn;
  assign ownAddr   = repeater_cfg_pkg::BUS_ADDR_BASE | {3'h0, addrPins};

  // Open-drain data pin: only ever pulls low
  assign sdaOut = 1'b0;

  // Acknowledge slots pull low; read bits pull low for zeros
  always_comb
  begin
    case (state)
      S_ACK_ADDR, S_ACK_REG, S_ACK_DATA: sdaOe = 1'b1;
      S_READ:                            sdaOe = !shiftReg[7];
      default:                           sdaOe = 1'b0;
    endcase
  end

  // Bus slave sequencing: sample on clock rise, drive after clock fall
  always_comb
  begin
    next_state    = state;
    next_bitCnt   = bitCnt;
    next_shiftReg = shiftReg;
    next_regAddr  = regAddr;
    next_readMode = readMode;
    next_hostAck  = hostAck;
    wrEn          = 1'b0;
    if (!mgmt_bus_enable_pin)
    begin
      next_state = S_IDLE;
    end
    else if (startSeen)
    begin
      next_state  = S_ADDR; // Repeated start also lands here
      next_bitCnt = 4'h0;
    end
    else if (stopSeen)
    begin
      next_state = S_IDLE;
    end
    else
    begin
      case (state)
        S_ADDR, S_REG, S_WDATA:
        begin
          if (sclRise)
          begin
            next_shiftReg = {shiftReg[6:0], sdaIn};
            next_bitCnt   = bitCnt + 4'h1;
          end
          else if (sclFall && bitCnt == repeater_cfg_pkg::BYTE_BITS)
          begin
            next_bitCnt = 4'h0;
            if (state == S_ADDR && shiftReg[7:1] == ownAddr)
            begin
              next_readMode = shiftReg[0];
              next_state    = S_ACK_ADDR;
            end
            else if (state == S_ADDR)
            begin
              next_state = S_IGNORE; // Not our address: stay off the bus
            end
            else if (state == S_REG)
            begin
              next_regAddr = shiftReg;
              next_state   = S_ACK_REG;
            end
            else
            begin
              wrEn       = 1'b1;
              next_state = S_ACK_DATA;
            end
          end
        end
        S_ACK_ADDR:
        begin
          if (sclFall && readMode)
          begin
            next_shiftReg = rdData;
            next_state    = S_READ;
          end
          else if (sclFall)
          begin
            next_state = S_REG;
          end
        end
        S_ACK_REG:
        begin
          if (sclFall)
            next_state = S_WDATA;
        end
        S_ACK_DATA:
        begin
          // Single data byte per write; further bytes are not acknowledged
          if (sclFall)
            next_state = S_IGNORE;
        end
        S_READ:
        begin
          if (sclFall && bitCnt == 4'h7)
          begin
            next_bitCnt = 4'h0;
            next_state  = S_READ_ACK;
          end
          else if (sclFall)
          begin
            next_shiftReg = {shiftReg[6:0], 1'b0};
            next_bitCnt   = bitCnt + 4'h1;
          end
        end
        S_READ_ACK:
        begin
          if (sclRise)
          begin
            next_hostAck = !sdaIn;
          end
          else if (sclFall && hostAck)
          begin
            next_shiftReg = rdData; // Host asked again: same register
            next_state    = S_READ;
          end
          else if (sclFall)
          begin
            next_state = S_IGNORE;
          end
        end
        S_IGNORE:
          next_state = S_IGNORE;
        default:
          next_state = S_IDLE;
      endcase
    end
  end

  // Slave state registers
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      state    <= S_IDLE;
      bitCnt   <= 4'h0;
      shiftReg <= 8'h00;
      regAddr  <= 8'h00;
      readMode <= 1'b0;
      hostAck  <= 1'b0;
      sclPrev  <= 1'b1;
      sdaPrev  <= 1'b1;
    end
    else if (ce)
    begin
      state    <= next_state;
      bitCnt   <= next_bitCnt;
      shiftReg <= next_shiftReg;
      regAddr  <= next_regAddr;
      readMode <= next_readMode;
      hostAck  <= next_hostAck;
      sclPrev  <= scl;
      sdaPrev  <= sdaIn;
    end
  end

  // Register storage with registered read data
  lane_cfg_bank u_bank
  (
    .clk    (clk),
    .rst_n  (rst_n),
    .ce     (ce),
    .wrEn   (wrEn),
    .wrAddr (regAddr),
    .wrData (shiftReg),
    .rdAddr (regAddr),
    .rdData (rdData),
    .cfg    (cfg)
  );

  // Pin versus register arbitration; pins alone while the bus is disabled
  always_comb
  begin
    next_laneCtrl = '0;
    if (mgmt_bus_enable_pin && cfg.powerDownOverride[repeater_cfg_pkg::BIT_PD_PIN_BLOCK])
      next_laneCtrl.lanePowerDown = cfg.lanePowerDown;
    else if (mgmt_bus_enable_pin)
      next_laneCtrl.lanePowerDown = cfg.lanePowerDown | {8{power_down_pin}};
    else
      next_laneCtrl.lanePowerDown = {8{power_down_pin}};

    if (mgmt_bus_enable_pin && cfg.pinOverride[repeater_cfg_pkg::BIT_IDLE_BLOCK]
        && cfg.idleRate[repeater_cfg_pkg::BIT_IDLE_AUTO])
    begin
      next_laneCtrl.laneB0Mute           = laneB0IdleDetected;
      next_laneCtrl.laneB0SignalDetectOn = 1'b1;
    end
    else if (mgmt_bus_enable_pin && cfg.pinOverride[repeater_cfg_pkg::BIT_IDLE_BLOCK])
    begin
      next_laneCtrl.laneB0Mute           = cfg.idleRate[repeater_cfg_pkg::BIT_IDLE_SEL];
      next_laneCtrl.laneB0SignalDetectOn = 1'b0;
    end
    else
    begin
      next_laneCtrl.laneB0Mute           = idlePin;
      next_laneCtrl.laneB0SignalDetectOn = 1'b1;
    end

    if (mgmt_bus_enable_pin && cfg.pinOverride[repeater_cfg_pkg::BIT_RATE_BLOCK]
        && cfg.idleRate[repeater_cfg_pkg::BIT_RATE_AUTO])
      next_laneCtrl.laneB0RateHigh = laneB0HighRateDetected;
    else if (mgmt_bus_enable_pin && cfg.pinOverride[repeater_cfg_pkg::BIT_RATE_BLOCK])
      next_laneCtrl.laneB0RateHigh = cfg.idleRate[repeater_cfg_pkg::BIT_RATE_SEL];
    else
      next_laneCtrl.laneB0RateHigh = ratePin;

    // Gain stage zero is bypass, leaving three real stages by eight boosts
    next_laneCtrl.laneB0GainStage = cfg.equalizer[repeater_cfg_pkg::POS_EQ_GAIN +: 2];
    next_laneCtrl.laneB0Boost     = cfg.equalizer[repeater_cfg_pkg::POS_EQ_BOOST +: 3];
    next_laneCtrl.laneB0EqActive  = cfg.equalizer[repeater_cfg_pkg::BIT_EQ_ENABLE]
                                    && (cfg.equalizer[repeater_cfg_pkg::POS_EQ_GAIN +: 2] != 2'h0);
  end

  // Lane control outputs from flip-flops
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      laneCtrl <= '0;
    end
    else if (ce)
    begin
      laneCtrl <= next_laneCtrl;
    end
  end

endmodule

`default_nettype wire

// ---- hdl/repeater_cfg_pkg.sv ----
package repeater_cfg_pkg;

  // Register offsets
  localparam logic [7:0] OFS_SOFT_RESET  = 8'h00;
  localparam logic [7:0] OFS_LANE_PD     = 8'h01;
  localparam logic [7:0] OFS_PD_OVERRIDE = 8'h02;
  localparam logic [7:0] OFS_PIN_OVR     = 8'h08;
  localparam logic [7:0] OFS_IDLE_RATE   = 8'h0E;
  localparam logic [7:0] OFS_EQ          = 8'h0F;

  // Reset values
  localparam logic [7:0] RST_SOFT_RESET  = 8'h00;
  localparam logic [7:0] RST_LANE_PD     = 8'h00;
  localparam logic [7:0] RST_PD_OVERRIDE = 8'h00;
  localparam logic [7:0] RST_PIN_OVR     = 8'h00;
  localparam logic [7:0] RST_IDLE_RATE   = 8'h00;
  localparam logic [7:0] RST_EQ          = 8'h20;

  // Field positions
  localparam int BIT_SOFT_RESET   = 0;
  localparam int BIT_PD_PIN_BLOCK = 0;
  localparam int BIT_IDLE_BLOCK   = 4;
  localparam int BIT_RATE_BLOCK   = 2;
  localparam int BIT_IDLE_AUTO    = 5;
  localparam int BIT_IDLE_SEL     = 4;
  localparam int BIT_RATE_AUTO    = 1;
  localparam int BIT_RATE_SEL     = 0;
  localparam int BIT_EQ_ENABLE    = 5;
  localparam int POS_EQ_GAIN      = 3;
  localparam int POS_EQ_BOOST     = 0;
  localparam int SIDE_A_LANE0     = 4;

  // Bus address: fixed upper bits, low four from the address straps
  localparam logic [6:0] BUS_ADDR_BASE = 7'h50;
  localparam logic [3:0] BYTE_BITS     = 4'h8;

  // Stored configuration bytes
  typedef struct packed {
    logic [7:0] softReset;
    logic [7:0] lanePowerDown;
    logic [7:0] powerDownOverride;
    logic [7:0] pinOverride;
    logic [7:0] idleRate;
    logic [7:0] equalizer;
  } cfg_t;

  // Effective lane controls driven to the analog lanes
  typedef struct packed {
    logic [7:0] lanePowerDown;
    logic       laneB0Mute;
    logic       laneB0SignalDetectOn;
    logic       laneB0RateHigh;
    logic       laneB0EqActive;
    logic [1:0] laneB0GainStage;
    logic [2:0] laneB0Boost;
  } lane_ctrl_t;

endpackage

// ---- hdl/lane_cfg_bank.sv ----
`timescale 1ns/1ps
`default_nettype none

module lane_cfg_bank
(
  // Clock and reset
  input  wire logic                    clk,
  input  wire logic                    rst_n,
  input  wire logic                    ce,
  // Write port
  input  wire logic                    wrEn,
  input  wire logic [7:0]              wrAddr,
  input  wire logic [7:0]              wrData,
  // Read port
  input  wire logic [7:0]              rdAddr,
  output logic      [7:0]              rdData,
  // Stored values
  output repeater_cfg_pkg::cfg_t       cfg
);

  repeater_cfg_pkg::cfg_t defaults;
  repeater_cfg_pkg::cfg_t next_cfg;
  logic [7:0]             next_rdData;

  assign defaults = '{softReset:         repeater_cfg_pkg::RST_SOFT_RESET,
                      lanePowerDown:     repeater_cfg_pkg::RST_LANE_PD,
                      powerDownOverride: repeater_cfg_pkg::RST_PD_OVERRIDE,
                      pinOverride:       repeater_cfg_pkg::RST_PIN_OVR,
                      idleRate:          repeater_cfg_pkg::RST_IDLE_RATE,
                      equalizer:         repeater_cfg_pkg::RST_EQ};

  // Write decode; reserved bits are kept but drive nothing
  always_comb
  begin
    next_cfg = cfg;
    if (wrEn && wrAddr == repeater_cfg_pkg::OFS_SOFT_RESET
        && wrData[repeater_cfg_pkg::BIT_SOFT_RESET])
    begin
      next_cfg = defaults;
    end
    else if (wrEn && wrAddr == repeater_cfg_pkg::OFS_SOFT_RESET)
    begin
      next_cfg.softReset = wrData;
    end
    else if (wrEn && wrAddr == repeater_cfg_pkg::OFS_LANE_PD)
    begin
      next_cfg.lanePowerDown = wrData;
    end
    else if (wrEn && wrAddr == repeater_cfg_pkg::OFS_PD_OVERRIDE)
    begin
      next_cfg.powerDownOverride = wrData;
    end
    else if (wrEn && wrAddr == repeater_cfg_pkg::OFS_PIN_OVR)
    begin
      next_cfg.pinOverride = wrData;
    end
    else if (wrEn && wrAddr == repeater_cfg_pkg::OFS_IDLE_RATE)
    begin
      next_cfg.idleRate = wrData;
    end
    else if (wrEn && wrAddr == repeater_cfg_pkg::OFS_EQ)
    begin
      next_cfg.equalizer = wrData;
    end
  end

  // Read mux; unmapped offsets read as zero
  always_comb
  begin
    if (rdAddr == repeater_cfg_pkg::OFS_SOFT_RESET)
      next_rdData = cfg.softReset;
    else if (rdAddr == repeater_cfg_pkg::OFS_LANE_PD)
      next_rdData = cfg.lanePowerDown;
    else if (rdAddr == repeater_cfg_pkg::OFS_PD_OVERRIDE)
      next_rdData = cfg.powerDownOverride;
    else if (rdAddr == repeater_cfg_pkg::OFS_PIN_OVR)
      next_rdData = cfg.pinOverride;
    else if (rdAddr == repeater_cfg_pkg::OFS_IDLE_RATE)
      next_rdData = cfg.idleRate;
    else if (rdAddr == repeater_cfg_pkg::OFS_EQ)
      next_rdData = cfg.equalizer;
    else
      next_rdData = 8'h00;
  end

  // Storage and registered read data
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      cfg    <= defaults;
      rdData <= 8'h00;
    end
    else if (ce)
    begin
      cfg    <= next_cfg;
      rdData <= next_rdData;
    end
  end

endmodule

`default_nettype wire

// ---- sim/repeater_lane_config_regs_assertions.sv ----
`timescale 1ns/1ps
`default_nettype none
module repeater_lane_config_regs_assertions
(
  // Clock and reset
  input wire logic                         clk,
  input wire logic                         rst_n,
  // Bus and pins
  input wire logic                         mgmt_bus_enable_pin,
  input wire logic                         scl,
  input wire logic                         sdaIn,
  input wire logic                         sdaOut,
  input wire logic                         sdaOe,
  input wire logic                         power_down_pin,
  input wire logic                         idlePin,
  input wire logic                         ratePin,
  // Lane controls
  input wire repeater_cfg_pkg::lane_ctrl_t laneCtrl
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Bus steps
  sequence s_start;
    scl && sdaIn ##1 scl && !sdaIn;
  endsequence
  sequence s_held;
    sdaOe [*6];
  endsequence
  // Properties
  property p_open_drain;
    sdaOut == 1'b0;
  endproperty
  property p_bus_off_quiet;
    !mgmt_bus_enable_pin ##1 !mgmt_bus_enable_pin |-> !sdaOe;
  endproperty
  property p_pd_pin_only;
    rst_n && !mgmt_bus_enable_pin |=> laneCtrl.lanePowerDown == {8{$past(power_down_pin)}};
  endproperty
  property p_idle_pin_only;
    rst_n && !mgmt_bus_enable_pin |=>
      laneCtrl.laneB0Mute == $past(idlePin) && laneCtrl.laneB0SignalDetectOn;
  endproperty
  property p_rate_pin_only;
    rst_n && !mgmt_bus_enable_pin |=> laneCtrl.laneB0RateHigh == $past(ratePin);
  endproperty
  property p_eq_active;
    laneCtrl.laneB0EqActive |-> laneCtrl.laneB0GainStage != 2'h0;
  endproperty
  // Data may only move while the clock is low, just after a fall
  property p_sda_change_low;
    $changed(sdaOe) |-> !scl && ($past(scl, 2) || $past(scl, 3));
  endproperty
  property p_ack_held;
    $rose(sdaOe) |-> s_held;
  endproperty
  property p_start_quiet;
    s_start |-> !sdaOe [*8];
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("sda driven high");
  a_bus_off_quiet: assert property (p_bus_off_quiet) else $error("drive while off");
  a_pd_pin_only: assert property (p_pd_pin_only) else $error("power pin lost");
  a_idle_pin_only: assert property (p_idle_pin_only) else $error("idle pin lost");
  a_rate_pin_only: assert property (p_rate_pin_only) else $error("rate pin lost");
  a_eq_active: assert property (p_eq_active) else $error("eq without stage");
  a_sda_change_low: assert property (p_sda_change_low) else $error("sda moved");
  a_ack_held: assert property (p_ack_held) else $error("ack too short");
  a_start_quiet: assert property (p_start_quiet) else $error("drive after start");
endmodule
bind repeater_lane_config_regs repeater_lane_config_regs_assertions
  repeater_lane_config_regs_assertions_i
(
  .clk(clk), .rst_n(rst_n), .mgmt_bus_enable_pin(mgmt_bus_enable_pin), .scl(scl),
  .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe), .power_down_pin(power_down_pin),
  .idlePin(idlePin), .ratePin(ratePin), .laneCtrl(laneCtrl)
);
`default_nettype wire

// ---- sim/smbus_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module smbus_host_model
(
  // Clock and wire
  input  wire logic clk,
  input  wire logic sdaLine,
  // Driven lines
  output logic      scl,
  output logic      sdaLow
);
  // Bus idles high
  initial
  begin
    scl = 1'b1;
    sdaLow = 1'b0;
  end
  // Phases of one, two or four clocks, above the slave's minimum
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // One bit; data moves a clock after the fall, for hold time
  task automatic sendBit(input logic b, output logic seen);
    sdaLow = !b;
    tick(4);
    scl = 1'b1;
    tick(2);
    seen = sdaLine;
    tick(2);
    scl = 1'b0;
    tick(1);
  endtask
  // Also a repeated start when the clock is low
  task automatic start();
    sdaLow = 1'b0;
    tick(4);
    scl = 1'b1;
    tick(4);
    sdaLow = 1'b1;
    tick(4);
    scl = 1'b0;
    tick(1);
  endtask
  task automatic stop();
    sdaLow = 1'b1;
    tick(4);
    scl = 1'b1;
    tick(4);
    sdaLow = 1'b0;
    tick(4);
  endtask
  // Eight bits MSB first, then a ninth released or sent as given
  task automatic sendByte(input logic [7:0] v, input logic last, output logic [7:0] got,
                          output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      sendBit(v[i], got[i]);
    sendBit(last, s);
    ack = !s;
  endtask
  task automatic writeReg(input logic [6:0] dev, input logic [7:0] ra, input logic [7:0] d,
                          output logic ok);
    logic [7:0] g;
    logic       a0;
    logic       a1;
    logic       a2;
    start();
    sendByte({dev, 1'b0}, 1'b1, g, a0);
    sendByte(ra, 1'b1, g, a1);
    sendByte(d, 1'b1, g, a2);
    stop();
    ok = a0 && a1 && a2;
  endtask
  task automatic readReg(input logic [6:0] dev, input logic [7:0] ra, output logic [7:0] d,
                         output logic ok);
    logic [7:0] g;
    logic       a0;
    logic       a1;
    logic       a2;
    logic       a3;
    start();
    sendByte({dev, 1'b0}, 1'b1, g, a0);
    sendByte(ra, 1'b1, g, a1);
    start();
    sendByte({dev, 1'b1}, 1'b1, g, a2);
    sendByte(8'hFF, 1'b1, d, a3);
    stop();
    ok = a0 && a1 && a2;
  endtask
endmodule
`default_nettype wire

// ---- sim/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
module testbench;
  // Stimulus and observed signals
  logic                         clk       = 1'b0;
  logic                         rst_n     = 1'b0;
  logic                         busEnable = 1'b1;
  logic [3:0]                   addrStrap = 4'h5;
  logic                         pdPin     = 1'b0;
  logic                         idlePin   = 1'b0;
  logic                         ratePin   = 1'b0;
  logic                         idleDet   = 1'b0;
  logic                         rateDet   = 1'b0;
  logic                         scl;
  logic                         hostSdaLow;
  logic                         sdaOut;
  logic                         sdaOe;
  wire                          sdaLine;
  repeater_cfg_pkg::lane_ctrl_t laneCtrl;
  int                           errors    = 0;
  int                           cmp_count = 0;
  logic [7:0]                   ofs [6]   = '{8'h00, 8'h01, 8'h02, 8'h08, 8'h0E, 8'h0F};
  logic [7:0]                   dflt [6]  = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h20};
  logic [7:0]                   masks [5] = '{8'h00, 8'hFF, 8'hA5, 8'h5A, 8'h10};
  localparam logic [6:0] DEV = repeater_cfg_pkg::BUS_ADDR_BASE | 7'h05;
  // Pull-up: a released line reads high
  assign sdaLine = !(hostSdaLow || sdaOe);
  always #20 clk = !clk;
  repeater_lane_config_regs repeater_lane_config_regs_i
  (
    .clk(clk), .rst_n(rst_n), .ce(1'b1), .mgmt_bus_enable_pin(busEnable),
    .addrPins(addrStrap), .scl(scl), .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOe(sdaOe),
    .power_down_pin(pdPin), .idlePin(idlePin), .ratePin(ratePin),
    .laneB0IdleDetected(idleDet), .laneB0HighRateDetected(rateDet), .laneCtrl(laneCtrl)
  );
  smbus_host_model smbus_host_model_i
  (
    .clk(clk), .sdaLine(sdaLine), .scl(scl), .sdaLow(hostSdaLow)
  );
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic checkByte(input string what, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic checkBit(input string what, input logic exp, input logic got);
    cmp_count++;
    if (got !== exp)
    begin
      errors++;
      $display("unexpected %s: expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] ra, input logic [7:0] d);
    logic ok;
    smbus_host_model_i.writeReg(DEV, ra, d, ok);
    checkBit("write ack", 1'b1, ok);
  endtask
  task automatic rd(input logic [7:0] ra, input logic [7:0] exp);
    logic       ok;
    logic [7:0] v;
    smbus_host_model_i.readReg(DEV, ra, v, ok);
    checkBit("read ack", 1'b1, ok);
    checkByte("register", exp, v);
  endtask
  // Lane outputs lag one clock; two clocks leave margin
  task automatic idleChk(input logic m, input logic sd);
    tick(2);
    checkBit("mute", m, laneCtrl.laneB0Mute);
    checkBit("detect on", sd, laneCtrl.laneB0SignalDetectOn);
  endtask
  task automatic rateChk(input logic r);
    tick(2);
    checkBit("rate", r, laneCtrl.laneB0RateHigh);
  endtask
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // Watchdog well beyond the expected run
  initial
  begin
    tick(90000);
    errors++;
    stop_test();
  end
  initial
  begin
    logic ok;
    tick(20);
    rst_n = 1'b1;
    tick(4);
    for (int i = 0; i < 6; i++)
      rd(ofs[i], dflt[i]);
    rd(8'h05, 8'h00);
    $display("test defaults done");
    wr(8'h02, 8'h01);
    foreach (masks[i])
    begin
      wr(8'h01, masks[i]);
      tick(2);
      checkByte("power down", masks[i], laneCtrl.lanePowerDown);
    end
    pdPin = 1'b1;
    tick(2);
    checkByte("pin blocked", 8'h10, laneCtrl.lanePowerDown);
    wr(8'h02, 8'h00);
    tick(2);
    checkByte("pin in control", 8'hFF, laneCtrl.lanePowerDown);
    pdPin = 1'b0;
    $display("test power down done");
    idlePin = 1'b1;
    idleChk(1'b1, 1'b1);
    wr(8'h08, 8'h10);
    wr(8'h0E, 8'h10);
    idleChk(1'b1, 1'b0);
    wr(8'h0E, 8'h00);
    idleChk(1'b0, 1'b0);
    wr(8'h0E, 8'h20);
    idleDet = 1'b1;
    idleChk(1'b1, 1'b1);
    idleDet = 1'b0;
    idleChk(1'b0, 1'b1);
    ratePin = 1'b1;
    wr(8'h08, 8'h14);
    wr(8'h0E, 8'h00);
    rateChk(1'b0);
    wr(8'h0E, 8'h01);
    rateChk(1'b1);
    wr(8'h0E, 8'h02);
    rateChk(1'b0);
    rateDet = 1'b1;
    rateChk(1'b1);
    wr(8'h08, 8'h00);
    rateDet = 1'b0;
    rateChk(1'b1);
    $display("test idle and rate done");
    for (int g = 0; g < 4; g++)
      for (int b = 0; b < 8; b++)
      begin
        wr(8'h0F, {3'b001, g[1:0], b[2:0]});
        rd(8'h0F, {3'b001, g[1:0], b[2:0]});
        checkByte("gain", {6'h00, g[1:0]}, {6'h00, laneCtrl.laneB0GainStage});
        checkByte("boost", {5'h00, b[2:0]}, {5'h00, laneCtrl.laneB0Boost});
        checkBit("eq on", g != 0, laneCtrl.laneB0EqActive);
      end
    wr(8'h0F, 8'h18);
    checkBit("eq off", 1'b0, laneCtrl.laneB0EqActive);
    $display("test equalizer done");
    wr(8'h01, 8'h5A);
    wr(8'h00, 8'h02);
    rd(8'h00, 8'h02);
    wr(8'h00, 8'h01);
    rd(8'h00, 8'h00);
    rd(8'h01, 8'h00);
    rd(8'h0F, 8'h20);
    $display("test soft reset done");
    addrStrap = 4'h6;
    smbus_host_model_i.writeReg(DEV, 8'h01, 8'h33, ok);
    checkBit("foreign ack", 1'b0, ok);
    addrStrap = 4'h5;
    rd(8'h01, 8'h00);
    busEnable = 1'b0;
    pdPin = 1'b1;
    smbus_host_model_i.writeReg(DEV, 8'h01, 8'h33, ok);
    checkBit("disabled ack", 1'b0, ok);
    checkByte("pins only", 8'hFF, laneCtrl.lanePowerDown);
    busEnable = 1'b1;
    pdPin = 1'b0;
    tick(4);
    rd(8'h01, 8'h00);
    $display("test refusals done");
    stop_test();
  end
endmodule
`default_nettype wire
